// *** rtl/ufei_pkg.sv ***
// package: register map, field layout and carrier types for endpoint irqs
package ufei_pkg;
    localparam int unsigned NUM_EP = 6;
    localparam int unsigned LOW_EP = 4;
    localparam logic [7:0] ADDR_ENABLE_LOW = 8'hA2;
    localparam logic [7:0] ADDR_ENABLE_HIGH = 8'hA3;
    localparam logic [7:0] ADDR_FLAG_LOW = 8'hC0;
    localparam logic [7:0] ADDR_FLAG_HIGH = 8'hC1;
    localparam logic [7:0] RESET_ENABLE_LOW = 8'h00;
    localparam logic [7:0] RESET_ENABLE_HIGH = 8'h00;
    localparam logic [7:0] RESET_FLAG_LOW = 8'h00;
    localparam logic [7:0] RESET_FLAG_HIGH = 8'h00;
    // bit 2n is transmit-done, bit 2n+1 receive-done
    localparam int unsigned TX_BIT = 0;
    localparam int unsigned RX_BIT = 1;
    localparam logic [7:0] HIGH_IMPL_MASK = 8'h0F;
    // reset value of the irq output
    localparam logic RESET_IRQ = 1'b0;

    typedef enum logic [1:0] {
        UFEI_TOK_OUT,
        UFEI_TOK_IN,
        UFEI_TOK_SETUP,
        UFEI_TOK_NONE
    } ufei_token_t;

    // one transaction result from the serial interface engine
    typedef struct packed {
        logic valid;
        ufei_token_t token;
        logic [2:0] endpoint;
        logic isochronous;
        logic data_received;
        logic timeout;
        logic seq_pid_error;
        logic tx_loaded_sent;
        logic ack_received;
    } ufei_sie_event_t;

    // per-endpoint control bits from the endpoint control register
    typedef struct packed {
        logic reception_enable;
        logic receive_path_enable;
        logic receive_stall;
        logic transmission_enable;
        logic transmit_path_enable;
        logic transmit_stall;
    } ufei_ep_ctrl_t;

    // special function register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ufei_sfr_req_t;
endpackage : ufei_pkg

// *** rtl/ufei_flag_reg.sv ***
// flag byte: hardware set, firmware write, set wins over clear
`timescale 1ns/1ns
module ufei_flag_reg (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // firmware write
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] mask_in,
    // hardware set pulses
    input wire logic [7:0] set_in,
    // stored flags
    output logic [7:0] flags_out
);
    typedef struct packed {
        logic [7:0] flags;
    } ufei_flag_state_t;

    ufei_flag_state_t state_reg;
    ufei_flag_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (wr_in) begin
            state_next.flags = wdata_in & mask_in;
        end
        state_next.flags = state_next.flags | (set_in & mask_in);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg.flags <= ufei_pkg::RESET_FLAG_LOW;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags_out = state_reg.flags;
endmodule : ufei_flag_reg

// *** rtl/ufei_endpoint_irq.sv ***
// endpoint receive/transmit done flags, enables and shared irq request
//
// Function
// - Each endpoint has rx-done and tx-done; isochronous never sets them.
// - Rx-done needs valid SETUP or OUT to endpoint with reception enabled.
// - OUT needs receive enable 1 and stall 0; SETUP bypasses both.
// - Rx-done on data without time-out or sequence PID error; others ignored.
// - Tx-done needs valid IN to endpoint with transmission enabled.
// - Tx-done also needs transmit enable 1 and transmit stall 0.
// - Tx-done needs loaded packet sent for the IN; FIFO errors ignored.
// - Tx-done set only after host ACK or engine time-out.
// - Flag bit 1 means pending, 0 means inactive.
// - Enable 1 lets flag interrupt; 0 blocks but flag still records.
// - Nothing reaches the CPU unless the USB function gate is set.
// - Low enable: bit 2n+1 endpoint n receive, bit 2n transmit.
// - High registers hold endpoints 4 and 5 in bits 3..0; 7:4 reserved.
// - Vector choice is the CPU's; flags never cleared on vectoring.
// - Priority 9 lives in the CPU priority logic, outside this block.
`timescale 1ns/1ns
module ufei_endpoint_irq (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // special function register access
    input wire ufei_pkg::ufei_sfr_req_t sfr_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    // serial interface engine transaction results
    input wire ufei_pkg::ufei_sie_event_t sie_event_in,
    // endpoint control bits, one set per endpoint
    input wire ufei_pkg::ufei_ep_ctrl_t [ufei_pkg::NUM_EP-1:0] ep_ctrl_in,
    // usb function gate bit from the usb irq enable register
    input wire logic usb_function_irq_gate_in,
    // shared interrupt request to the CPU
    output logic function_irq_out
);
    typedef struct packed {
        logic [7:0] enable_low;
        logic [7:0] enable_high;
        logic [7:0] rdata;
        logic hit;
        logic irq;
    } ufei_state_t;

    ufei_state_t state_reg;
    ufei_state_t state_next;
    logic [2*ufei_pkg::NUM_EP-1:0] set_pulse;
    logic [2*ufei_pkg::NUM_EP-1:0] flag_all;
    logic [7:0] flag_low;
    logic [7:0] flag_high;
    logic [7:0] set_high;
    logic rx_ok;
    logic tx_ok;

    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] b);
        addr_is = (a == b);
    endfunction : addr_is

    // crc, stuffing and fifo errors do not block
    assign rx_ok = sie_event_in.valid && !sie_event_in.isochronous
        && sie_event_in.data_received && !sie_event_in.timeout
        && !sie_event_in.seq_pid_error;
    // packet loaded and sent, fifo errors ignored
    // ack or engine time-out completes it
    assign tx_ok = sie_event_in.valid && !sie_event_in.isochronous
        && (sie_event_in.token == ufei_pkg::UFEI_TOK_IN)
        && sie_event_in.tx_loaded_sent
        && (sie_event_in.ack_received || sie_event_in.timeout);

    generate
        for (genvar n = 0; n < ufei_pkg::NUM_EP; n++) begin : g_ep
            logic hit_ep;
            logic rx_tok_ok;
            assign hit_ep = (sie_event_in.endpoint == 3'(n));
            assign rx_tok_ok = ep_ctrl_in[n].reception_enable
                && ((sie_event_in.token == ufei_pkg::UFEI_TOK_SETUP)
                || ((sie_event_in.token == ufei_pkg::UFEI_TOK_OUT)
                && ep_ctrl_in[n].receive_path_enable
                && !ep_ctrl_in[n].receive_stall));
            assign set_pulse[2*n+ufei_pkg::RX_BIT] =
                hit_ep && rx_ok && rx_tok_ok;
            // transmit enable set and not stalled
            assign set_pulse[2*n+ufei_pkg::TX_BIT] = hit_ep && tx_ok
                && ep_ctrl_in[n].transmission_enable
                && ep_ctrl_in[n].transmit_path_enable
                && !ep_ctrl_in[n].transmit_stall;
        end
    endgenerate

    // endpoints 4 and 5 in the high byte
    assign set_high = {4'h0, set_pulse[2*ufei_pkg::NUM_EP-1:8]};

    ufei_flag_reg u_flag_low (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .wr_in(sfr_in.wr && addr_is(sfr_in.addr, ufei_pkg::ADDR_FLAG_LOW)),
        .wdata_in(sfr_in.wdata),
        .mask_in(8'hFF),
        .set_in(set_pulse[7:0]),
        .flags_out(flag_low)
    );

    ufei_flag_reg u_flag_high (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .wr_in(sfr_in.wr && addr_is(sfr_in.addr, ufei_pkg::ADDR_FLAG_HIGH)),
        .wdata_in(sfr_in.wdata),
        .mask_in(ufei_pkg::HIGH_IMPL_MASK),
        .set_in(set_high),
        .flags_out(flag_high)
    );

    assign flag_all = {flag_high[3:0], flag_low};

    always_comb begin
        state_next = state_reg;
        if (sfr_in.wr) begin
            if (addr_is(sfr_in.addr, ufei_pkg::ADDR_ENABLE_LOW)) begin
                state_next.enable_low = sfr_in.wdata;
            end else if (addr_is(sfr_in.addr,
                                 ufei_pkg::ADDR_ENABLE_HIGH)) begin
                state_next.enable_high =
                    sfr_in.wdata & ufei_pkg::HIGH_IMPL_MASK;
            end
        end
        state_next.hit = 1'b0;
        state_next.rdata = 8'h00;
        if (sfr_in.rd) begin
            if (addr_is(sfr_in.addr, ufei_pkg::ADDR_ENABLE_LOW)) begin
                state_next.hit = 1'b1;
                state_next.rdata = state_reg.enable_low;
            end else if (addr_is(sfr_in.addr,
                                 ufei_pkg::ADDR_ENABLE_HIGH)) begin
                state_next.hit = 1'b1;
                state_next.rdata = state_reg.enable_high;
            end else if (addr_is(sfr_in.addr,
                                 ufei_pkg::ADDR_FLAG_LOW)) begin
                state_next.hit = 1'b1;
                state_next.rdata = flag_low;
            end else if (addr_is(sfr_in.addr,
                                 ufei_pkg::ADDR_FLAG_HIGH)) begin
                state_next.hit = 1'b1;
                state_next.rdata = flag_high;
            end
        end
        // level request, no clear on vectoring
        // one shared request, priority decided by the cpu
        state_next.irq = usb_function_irq_gate_in && |(flag_all
            & {state_reg.enable_high[3:0], state_reg.enable_low});
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg.enable_low <= ufei_pkg::RESET_ENABLE_LOW;
            state_reg.enable_high <= ufei_pkg::RESET_ENABLE_HIGH;
            state_reg.rdata <= 8'h00;
            state_reg.hit <= 1'b0;
            state_reg.irq <= ufei_pkg::RESET_IRQ;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sfr_rdata_out = state_reg.rdata;
    assign sfr_hit_out = state_reg.hit;
    assign function_irq_out = state_reg.irq;
endmodule : ufei_endpoint_irq

// *** bench/ufei_endpoint_irq_asserts.sv ***
// port assertions for the endpoint irq block
`timescale 1ns/1ns
module ufei_endpoint_irq_asserts (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // watched ports
    input wire ufei_pkg::ufei_sfr_req_t sfr_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic sfr_hit_out,
    input wire ufei_pkg::ufei_sie_event_t sie_event_in,
    input wire logic usb_function_irq_gate_in,
    input wire logic function_irq_out
);
    logic map_rd;
    assign map_rd = sfr_in.rd && (sfr_in.addr inside {
        ufei_pkg::ADDR_ENABLE_LOW,
        ufei_pkg::ADDR_ENABLE_HIGH, ufei_pkg::ADDR_FLAG_LOW,
        ufei_pkg::ADDR_FLAG_HIGH});
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    a_read_hit: assert property (map_rd |=> sfr_hit_out)
        else $error("hit missing after mapped read");
    a_unmapped_quiet: assert property (!map_rd |=> !sfr_hit_out)
        else $error("hit without mapped read");
    a_idle_rdata: assert property (!sfr_hit_out
        |-> sfr_rdata_out == 8'h00)
        else $error("read data not zero outside a hit");
    a_flag_rsv: assert property (sfr_in.rd &&
        sfr_in.addr == ufei_pkg::ADDR_FLAG_HIGH
        |=> sfr_rdata_out[7:4] == 4'h0)
        else $error("reserved flag bits read nonzero");
    a_enable_rsv: assert property (sfr_in.rd &&
        sfr_in.addr == ufei_pkg::ADDR_ENABLE_HIGH
        |=> sfr_rdata_out[7:4] == 4'h0)
        else $error("reserved enable bits read nonzero");
    a_gate_blocks: assert property (!usb_function_irq_gate_in [*2]
        |-> !function_irq_out)
        else $error("irq raised with gate low");
    a_reset_quiet: assert property ($fell(srst_in)
        |-> !function_irq_out && !sfr_hit_out)
        else $error("outputs active after reset");
    // write then read back with no engine event in between
    a_flag_store: assert property ((sfr_in.wr &&
        sfr_in.addr == ufei_pkg::ADDR_FLAG_LOW && !sie_event_in.valid)
        ##1 (!sie_event_in.valid && !sfr_in.wr)
        ##1 (sfr_in.rd && sfr_in.addr == ufei_pkg::ADDR_FLAG_LOW)
        |=> sfr_rdata_out == $past(sfr_in.wdata, 3))
        else $error("flag write not stored");
    c_irq: cover property ($rose(function_irq_out));
    c_read: cover property (map_rd);
    c_event: cover property (sie_event_in.valid);
endmodule : ufei_endpoint_irq_asserts
bind ufei_endpoint_irq ufei_endpoint_irq_asserts u_ufei_endpoint_irq_asserts (
    .clk_in(clk_in), .srst_in(srst_in), .sfr_in(sfr_in),
    .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out),
    .sie_event_in(sie_event_in),
    .usb_function_irq_gate_in(usb_function_irq_gate_in),
    .function_irq_out(function_irq_out));

// *** bench/ufei_sie_model.sv ***
// serial engine stand-in: one result pulse per call
`timescale 1ns/1ns
module ufei_sie_model (
    // clock
    input wire logic clk_in,
    // transaction result
    output ufei_pkg::ufei_sie_event_t event_out
);
    initial event_out = '0;
    task automatic send(input ufei_pkg::ufei_sie_event_t ev);
        @(negedge clk_in);
        event_out = ev;
        @(negedge clk_in);
        // idle fields flip so stale values never look valid
        event_out = ~ev & 12'h7FF;
    endtask : send
endmodule : ufei_sie_model

// *** bench/tb.sv ***
// self-checking bench for the endpoint irq block
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        ufei_pkg::ufei_token_t tok;
        logic [2:0] ep;
        logic [5:0] f;
        logic [5:0] c;
        logic [15:0] exp;
    } ufei_row_t;
    localparam ufei_pkg::ufei_token_t T_OUT = ufei_pkg::UFEI_TOK_OUT;
    localparam ufei_pkg::ufei_token_t T_IN = ufei_pkg::UFEI_TOK_IN;
    localparam ufei_pkg::ufei_token_t T_SET = ufei_pkg::UFEI_TOK_SETUP;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    ufei_pkg::ufei_sfr_req_t sfr = '0;
    ufei_pkg::ufei_sie_event_t sev;
    ufei_pkg::ufei_ep_ctrl_t [ufei_pkg::NUM_EP-1:0] ctrl = '0;
    logic gate = 1'b0;
    logic [7:0] rdata, d, hi;
    logic hit, h, irq;
    int fail_count = 0;
    int num_checks = 0;
    ufei_row_t rows [17];
    always #4 clk_in = ~clk_in;
    ufei_sie_model u_ufei_sie_model (.clk_in(clk_in), .event_out(sev));
    ufei_endpoint_irq u_ufei_endpoint_irq (.clk_in(clk_in),
        .srst_in(srst_in), .sfr_in(sfr), .sfr_rdata_out(rdata),
        .sfr_hit_out(hit), .sie_event_in(sev), .ep_ctrl_in(ctrl),
        .usb_function_irq_gate_in(gate), .function_irq_out(irq));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] wd);
        @(negedge clk_in);
        sfr = '{wr: w, rd: !w, addr: a, wdata: wd};
        @(negedge clk_in);
        sfr = '0;
        d = rdata;
        h = hit;
    endtask : acc
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end
    initial begin
        rows = '{'{T_OUT, 3'h1, 6'h10, 6'h36, 16'h0008},
            '{T_OUT, 3'h1, 6'h30, 6'h36, 16'h0000},
            '{T_OUT, 3'h2, 6'h18, 6'h36, 16'h0000},
            '{T_OUT, 3'h0, 6'h14, 6'h36, 16'h0000},
            '{T_OUT, 3'h3, 6'h10, 6'h3E, 16'h0000},
            '{T_SET, 3'h3, 6'h10, 6'h2E, 16'h0080},
            '{T_SET, 3'h0, 6'h10, 6'h1E, 16'h0000},
            '{T_IN, 3'h2, 6'h03, 6'h36, 16'h0010},
            '{T_IN, 3'h4, 6'h0A, 6'h36, 16'h0100},
            '{T_IN, 3'h5, 6'h02, 6'h36, 16'h0000},
            '{T_IN, 3'h1, 6'h01, 6'h36, 16'h0000},
            '{T_IN, 3'h1, 6'h03, 6'h37, 16'h0000},
            '{T_OUT, 3'h5, 6'h10, 6'h36, 16'h0800},
            '{T_IN, 3'h0, 6'h03, 6'h34, 16'h0000},
            '{T_IN, 3'h0, 6'h03, 6'h32, 16'h0000},
            '{T_IN, 3'h3, 6'h23, 6'h36, 16'h0000},
            '{T_OUT, 3'h6, 6'h10, 6'h36, 16'h0000}};
        repeat (16) @(negedge clk_in);
        srst_in = 1'b0;
        foreach (rows[i]) begin
            ctrl = {ufei_pkg::NUM_EP{rows[i].c}};
            acc(1'b1, ufei_pkg::ADDR_FLAG_LOW, 8'h00);
            acc(1'b1, ufei_pkg::ADDR_FLAG_HIGH, 8'h00);
            u_ufei_sie_model.send({1'b1, rows[i].tok, rows[i].ep, rows[i].f});
            acc(1'b0, ufei_pkg::ADDR_FLAG_HIGH, 8'h00);
            hi = d;
            acc(1'b0, ufei_pkg::ADDR_FLAG_LOW, 8'h00);
            chk({hi, d}, rows[i].exp);
        end
        gate = 1'b1;
        acc(1'b1, ufei_pkg::ADDR_ENABLE_LOW, 8'h08);
        acc(1'b1, ufei_pkg::ADDR_FLAG_LOW, 8'h08);
        acc(1'b0, ufei_pkg::ADDR_FLAG_LOW, 8'h00);
        chk({8'h00, d}, 16'h0008);
        chk({15'h0, irq}, 16'h0001);
        gate = 1'b0;
        repeat (2) @(negedge clk_in);
        chk({15'h0, irq}, 16'h0000);
        gate = 1'b1;
        acc(1'b1, ufei_pkg::ADDR_ENABLE_LOW, 8'h04);
        acc(1'b0, ufei_pkg::ADDR_FLAG_LOW, 8'h00);
        chk({7'h0, irq, d}, 16'h0008);
        acc(1'b1, ufei_pkg::ADDR_ENABLE_HIGH, 8'hFF);
        acc(1'b0, ufei_pkg::ADDR_ENABLE_HIGH, 8'h00);
        chk({7'h0, h, d}, 16'h010F);
        acc(1'b0, 8'h55, 8'h00);
        chk({7'h0, h, d}, 16'h0000);
        srst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        acc(1'b0, ufei_pkg::ADDR_ENABLE_LOW, 8'h00);
        hi = d;
        acc(1'b0, ufei_pkg::ADDR_ENABLE_HIGH, 8'h00);
        chk({hi, d}, 16'h0000);
        acc(1'b0, ufei_pkg::ADDR_FLAG_LOW, 8'h00);
        hi = d;
        acc(1'b0, ufei_pkg::ADDR_FLAG_HIGH, 8'h00);
        chk({hi | {7'h0, irq}, d}, 16'h0000);
        end_of_test();
    end
endmodule : tb
